// >>> hdl/gplc_top.sv
// gate pattern combiner with its local bus register bank
`timescale 1ns/10ps
module gplc_top #(
    parameter logic [31:0]                  FW_REVISION = 32'h0000_0001 // arbitrary value
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [gplc_pkg::DATA_W-1:0] portA,
    input  wire logic [gplc_pkg::DATA_W-1:0] portB,
    output logic      [gplc_pkg::DATA_W-1:0] portC,
    input  wire logic [gplc_pkg::ADDR_W-1:0] lbAddr,
    input  wire logic                       lbWrite,
    input  wire logic                       lbRead,
    input  wire logic                       lbBlock,
    input  wire logic [gplc_pkg::DATA_W-1:0] lbWdata,
    output logic      [gplc_pkg::DATA_W-1:0] lbRdata,
    output logic                            lbAck,
    output logic                            lbError
);
    import gplc_pkg::*;

    logic [DATA_W-1:0] maskA;
    logic [DATA_W-1:0] maskB;
    logic [DATA_W-1:0] control;
    logic [DATA_W-1:0] swValue;
    logic [DATA_W-1:0] liveA;
    logic [DATA_W-1:0] liveB;
    logic [DATA_W-1:0] capA;
    logic [DATA_W-1:0] capB;
    logic [DATA_W-1:0] capAnd;
    logic [DATA_W-1:0] capOr;
    logic [DATA_W-1:0] next_portC;
    logic [DATA_W-1:0] next_rdata;
    logic [SEL_W-1:0]  sel;
    logic              inUser;
    logic              blockOk;
    logic              accWr;
    logic              accRd;
    logic              capClear;

    // decode of the user window; block cycles are refused here
    function automatic logic inWindow(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    assign inUser   = inWindow(lbAddr, USER_LO, USER_HI); // RULE7
    assign blockOk  = inWindow(lbAddr, 16'h0000, BLOCK_HI); // RULE6
    assign accWr    = lbWrite && inUser && !lbBlock; // RULE5
    assign accRd    = lbRead && inUser && !lbBlock;
    assign sel      = control[SEL_LSB +: SEL_W];
    assign capClear = accWr && (lbAddr == OFS_CONTROL) && lbWdata[CAPCLR_BIT];

    // masked channels contribute zero
    assign liveA = portA & ~maskA; // RULE13 RULE11
    assign liveB = portB & ~maskB; // RULE13

    gplc_capture u_capture (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (capClear),
        .liveA  (liveA),
        .liveB  (liveB),
        .capA   (capA),
        .capB   (capB),
        .capAnd (capAnd),
        .capOr  (capOr)
    );

    // writable registers; monitor offsets fall through so writes are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            maskA   <= RST_WORD; // RULE14
            maskB   <= RST_WORD;
            control <= RST_WORD;
            swValue <= RST_WORD;
        end else if (accWr) begin
            unique case (lbAddr)
                OFS_MASK_A:   maskA   <= lbWdata; // RULE11 RULE8
                OFS_MASK_B:   maskB   <= lbWdata;
                OFS_CONTROL:  control <= lbWdata & ~(32'h1 << CAPCLR_BIT);
                OFS_SW_VALUE: swValue <= lbWdata; // RULE12
                default:      ; // RULE15
            endcase
        end
    end

    // output selector
    always_comb begin
        unique case (sel) // RULE1
            SEL_A:       next_portC = liveA; // RULE2
            SEL_B:       next_portC = liveB;
            SEL_AND:     next_portC = liveA & liveB;
            SEL_OR:      next_portC = liveA | liveB;
            SEL_CAP_A:   next_portC = capA; // RULE3
            SEL_CAP_B:   next_portC = capB;
            SEL_CAP_AND: next_portC = capAnd;
            SEL_CAP_OR:  next_portC = capOr;
            SEL_SW:      next_portC = swValue; // RULE12
            SEL_ZERO:    next_portC = RST_WORD;
            default:     next_portC = RST_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portC <= RST_WORD;
        end else begin
            portC <= next_portC; // RULE4
        end
    end

    // read mux
    always_comb begin
        unique case (lbAddr) // RULE8
            OFS_VERSION:  next_rdata = FW_REVISION;
            OFS_PORT_A:   next_rdata = portA; // RULE10
            OFS_PORT_B:   next_rdata = portB;
            OFS_PORT_C:   next_rdata = portC;
            OFS_STATUS:   next_rdata = {29'h0, (sel > SEL_ZERO), (|capOr), 1'b1};
            OFS_MASK_A:   next_rdata = maskA;
            OFS_MASK_B:   next_rdata = maskB;
            OFS_CONTROL:  next_rdata = control;
            OFS_SW_VALUE: next_rdata = swValue;
            default:      next_rdata = RST_WORD; // RULE15
        endcase
    end

    // one-cycle answer for every access; out-of-window or bad block gives error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lbRdata <= RST_WORD;
            lbAck   <= 1'b0;
            lbError <= 1'b0;
        end else begin
            lbAck   <= lbRead || lbWrite;
            lbError <= (lbRead || lbWrite) && (lbBlock ? !blockOk : !inUser); // RULE6 RULE7
            lbRdata <= accRd ? next_rdata : RST_WORD;
        end
    end
endmodule

// >>> hdl/gplc_pkg.sv
// package with register map, field layout and reset values of the gate pattern combiner
// Overview of operation
// [RULE1] control low nibble picks one of ten sources
// [RULE2] sources: A, B, A and B, A or B
// [RULE3] capture sources set bits and hold them
// [RULE4] port C is 32 lines, one per channel
// [RULE5] all registers 32 bits, single access
// [RULE6] block transfers only below 0x1000
// [RULE7] registers decoded only in 0x1000-0x7fff
// [RULE8] config window then monitor window; code puts monitor at 0x1000, config at 0x1800
// [RULE9] host should use 32-bit transfers
// [RULE10] read back live A, B and C
// [RULE11] read/write masks for A and B
// [RULE12] read/write software value drives C option
// [RULE13] mask bit one excludes that channel
// [RULE14] reset clears masks, control, value, capture
// [RULE15] read-only writes ignored, holes read zero
package gplc_pkg;
    localparam int            DATA_W        = 32;
    localparam int            ADDR_W        = 16;
    localparam logic [15:0]   USER_LO       = 16'h1000;
    localparam logic [15:0]   USER_HI       = 16'h7fff;
    localparam logic [15:0]   BLOCK_HI      = 16'h0fff;
    localparam logic [15:0]   OFS_VERSION   = 16'h1000;
    localparam logic [15:0]   OFS_PORT_A    = 16'h1004;
    localparam logic [15:0]   OFS_PORT_B    = 16'h1008;
    localparam logic [15:0]   OFS_PORT_C    = 16'h100c;
    localparam logic [15:0]   OFS_STATUS    = 16'h1010;
    localparam logic [15:0]   OFS_MASK_A    = 16'h1800;
    localparam logic [15:0]   OFS_MASK_B    = 16'h1804;
    localparam logic [15:0]   OFS_CONTROL   = 16'h1808;
    localparam logic [15:0]   OFS_SW_VALUE  = 16'h180c;
    localparam logic [31:0]   RST_WORD      = 32'h0000_0000;
    localparam int            SEL_LSB       = 0;
    localparam int            SEL_W         = 4;
    localparam int            CAPCLR_BIT    = 4;
    // selector codes for port C
    localparam logic [3:0]    SEL_A         = 4'h0;
    localparam logic [3:0]    SEL_B         = 4'h1;
    localparam logic [3:0]    SEL_AND       = 4'h2;
    localparam logic [3:0]    SEL_OR        = 4'h3;
    localparam logic [3:0]    SEL_CAP_A     = 4'h4;
    localparam logic [3:0]    SEL_CAP_B     = 4'h5;
    localparam logic [3:0]    SEL_CAP_AND   = 4'h6;
    localparam logic [3:0]    SEL_CAP_OR    = 4'h7;
    localparam logic [3:0]    SEL_SW        = 4'h8;
    localparam logic [3:0]    SEL_ZERO      = 4'h9;
    // status bits
    localparam int            ST_READY_BIT  = 0;
    localparam int            ST_ANYCAP_BIT = 1;
    localparam int            ST_BADSEL_BIT = 2;
endpackage

// >>> hdl/gplc_capture.sv
// sticky capture of the four combined patterns
`timescale 1ns/10ps
module gplc_capture (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clear,
    input  wire logic [gplc_pkg::DATA_W-1:0] liveA,
    input  wire logic [gplc_pkg::DATA_W-1:0] liveB,
    output logic      [gplc_pkg::DATA_W-1:0] capA,
    output logic      [gplc_pkg::DATA_W-1:0] capB,
    output logic      [gplc_pkg::DATA_W-1:0] capAnd,
    output logic      [gplc_pkg::DATA_W-1:0] capOr
);
    import gplc_pkg::*;

    // a new bit in the clear cycle is kept: set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capA   <= RST_WORD; // RULE14
            capB   <= RST_WORD;
            capAnd <= RST_WORD;
            capOr  <= RST_WORD;
        end else begin
            capA   <= (clear ? RST_WORD : capA) | liveA; // RULE3
            capB   <= (clear ? RST_WORD : capB) | liveB;
            capAnd <= (clear ? RST_WORD : capAnd) | (liveA & liveB);
            capOr  <= (clear ? RST_WORD : capOr) | (liveA | liveB);
        end
    end
endmodule

// >>> testbench/gplc_top_props.sv
// port assertions of the gate pattern combiner
`timescale 1ns/10ps
module gplc_top_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [31:0] portA,
    input wire logic [31:0] portC,
    input wire logic [15:0] lbAddr,
    input wire logic        lbWrite,
    input wire logic        lbRead,
    input wire logic        lbBlock,
    input wire logic [31:0] lbRdata,
    input wire logic        lbAck,
    input wire logic        lbError
);
    wire req = lbRead | lbWrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ack; req |=> lbAck; endproperty
    a_ack: assert property (p_ack) else $error("no ack after strobe");
    property p_idle; !req |=> !lbAck && !lbError && lbRdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("bus answer without strobe");
    property p_win; req && !lbBlock && (lbAddr < 16'h1000 || lbAddr > 16'h7fff) |=> lbError && lbRdata == 32'h0; endproperty
    a_win: assert property (p_win) else $error("access outside window accepted");
    property p_in; req && !lbBlock && lbAddr inside {[16'h1000:16'h7fff]} |=> !lbError; endproperty
    a_in: assert property (p_in) else $error("access inside window refused");
    property p_blk; req && lbBlock |=> lbError == ($past(lbAddr) > 16'h0fff); endproperty
    a_blk: assert property (p_blk) else $error("block transfer range wrong");
    property p_rda; lbRead && !lbBlock && lbAddr == 16'h1004 |=> lbRdata == $past(portA); endproperty
    a_rda: assert property (p_rda) else $error("port A readback wrong");
    property p_rdc; lbRead && !lbBlock && lbAddr == 16'h100c |=> lbRdata == $past(portC); endproperty
    a_rdc: assert property (p_rdc) else $error("port C readback wrong");
    property p_hole; lbRead && !lbBlock && lbAddr == 16'h1014 |=> lbRdata == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule
bind gplc_top gplc_top_props u_props (.clk(clk), .rst_n(rst_n), .portA(portA), .portC(portC), .lbAddr(lbAddr),
    .lbWrite(lbWrite), .lbRead(lbRead), .lbBlock(lbBlock), .lbRdata(lbRdata), .lbAck(lbAck), .lbError(lbError));

// >>> testbench/gplc_host.sv
// local bus host model issuing single word accesses
`timescale 1ns/10ps
module gplc_host (
    input  wire logic        clk,
    input  wire logic [31:0] lbRdata,
    input  wire logic        lbError,
    output logic      [15:0] lbAddr,
    output logic             lbWrite,
    output logic             lbRead,
    output logic             lbBlock,
    output logic      [31:0] lbWdata
);
    initial begin
        {lbWrite, lbRead, lbBlock, lbAddr, lbWdata} = '0;
    end
    // one strobe pulse per whole word, released lines show the inverse
    task acc(input logic w, blk, input logic [15:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge clk);
        {lbWrite, lbRead, lbBlock, lbAddr, lbWdata} <= {w, ~w, blk, a, d};
        @(posedge clk);
        {lbWrite, lbRead, lbBlock, lbAddr, lbWdata} <= {2'b00, ~blk, ~a, ~d};
        @(posedge clk);
        rd = lbRdata;
        er = lbError;
    endtask
endmodule

// >>> testbench/gplc_top_tb.sv
// self-checking bench of the gate pattern combiner
`timescale 1ns/10ps
module gplc_top_tb;
    import gplc_pkg::*;
    localparam logic [31:0] REV = 32'h0000_00a5; // arbitrary value
    logic        clk = 1'b0, rst_n = 1'b0, lbWrite, lbRead, lbBlock, lbAck, lbError, er;
    logic [31:0] portA = '0, portB = '0, portC, lbRdata, lbWdata, rdv, a1, b1, a2, b2, e;
    logic [15:0] lbAddr;
    logic [15:0] rw [4] = '{OFS_MASK_A, OFS_MASK_B, OFS_CONTROL, OFS_SW_VALUE};
    logic [31:0] v [4];
    int          fails = 0, compares = 0, cyc = 0;
    always #2 clk = ~clk;
    gplc_top #(.FW_REVISION(REV)) DUT (.clk(clk), .rst_n(rst_n), .portA(portA), .portB(portB), .portC(portC),
        .lbAddr(lbAddr), .lbWrite(lbWrite), .lbRead(lbRead), .lbBlock(lbBlock), .lbWdata(lbWdata),
        .lbRdata(lbRdata), .lbAck(lbAck), .lbError(lbError));
    gplc_host host (.clk(clk), .lbRdata(lbRdata), .lbError(lbError), .lbAddr(lbAddr), .lbWrite(lbWrite),
        .lbRead(lbRead), .lbBlock(lbBlock), .lbWdata(lbWdata));
    task final_report;
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        host.acc(1'b1, 1'b0, a, d, rdv, er);
    endtask
    task rdc(input string nm, input logic [15:0] a, input logic [31:0] x);
        host.acc(1'b0, 1'b0, a, '0, rdv, er);
        check(nm, rdv, x);
    endtask
    function automatic logic [31:0] expc(input int s, input logic [31:0] a, b, sw);
        if (s == 8) return sw;
        if (s > 7) return '0;
        case (s % 4)
            0: return a;
            1: return b;
            2: return a & b;
            default: return a | b;
        endcase
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            final_report;
        end
    end
    initial begin
        rdv = $urandom(36457);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc("version", OFS_VERSION, REV);
        rdc("status", OFS_STATUS, 32'h1);
        for (int i = 0; i < 4; i++) rdc("rstval", rw[i], RST_WORD);
        for (int i = 0; i < 4; i++) begin
            v[i] = (i == 2) ? 32'h9 : $urandom;
            wr(rw[i], v[i]);
            rdc("rwback", rw[i], v[i]);
        end
        wr(OFS_VERSION, '1);
        rdc("rowrite", OFS_VERSION, REV);
        rdc("hole", 16'h1014, '0);
        host.acc(1'b0, 1'b0, 16'h8000, '0, rdv, er);
        check("outwin", {31'h0, er}, 32'h1);
        host.acc(1'b0, 1'b1, 16'h0100, '0, rdv, er);
        check("blklow", {31'h0, er}, 32'h0);
        host.acc(1'b1, 1'b1, OFS_SW_VALUE, '0, rdv, er);
        check("blkhigh", {31'h0, er}, 32'h1);
        rdc("blkwrite", OFS_SW_VALUE, v[3]);
        for (int s = 0; s < 16; s++) begin
            portA <= '0;
            portB <= '0;
            wr(OFS_CONTROL, 32'(s) | 32'h10);
            {a1, b1, a2, b2} = {$urandom, $urandom, $urandom, $urandom};
            {portA, portB} <= {a1, b1};
            repeat (2) @(posedge clk);
            {portA, portB} <= {a2, b2};
            repeat (3) @(posedge clk);
            e = expc(s, a2 & ~v[0], b2 & ~v[1], v[3]);
            if (s inside {[4:7]}) e |= expc(s, a1 & ~v[0], b1 & ~v[1], v[3]);
            @(negedge clk);
            check("portC", portC, e);
            rdc("regC", OFS_PORT_C, e);
            rdc("regA", OFS_PORT_A, a2);
            rdc("regB", OFS_PORT_B, b2);
            rdc("ctlrd", OFS_CONTROL, 32'(s));
            rdc("status", OFS_STATUS, {29'h0, (s > 9), |(((a1 | a2) & ~v[0]) | ((b1 | b2) & ~v[1])), 1'b1});
        end
        final_report;
    end
endmodule
